// File: core/icd_defines.vh
// icd_defines.vh: constants of the instruction class decoder
`ifndef ICD_DEFINES_VH
`define ICD_DEFINES_VH
// condition code bit positions and reset value
`define ICD_CCR_H 4
`define ICD_CCR_I 3
`define ICD_CCR_N 2
`define ICD_CCR_Z 1
`define ICD_CCR_C 0
`define ICD_CCR_RST 5'h08
// instruction classes
`define ICD_CLS_REGMEM 3'h0
`define ICD_CLS_RMW 3'h1
`define ICD_CLS_JMPBR 3'h2
`define ICD_CLS_BITMAN 3'h3
`define ICD_CLS_CTRL 3'h4
`define ICD_CLS_ILL 3'h7
// addressing modes
`define ICD_MODE_INH 3'h0
`define ICD_MODE_IMM 3'h1
`define ICD_MODE_DIR 3'h2
`define ICD_MODE_EXT 3'h3
`define ICD_MODE_IX 3'h4
`define ICD_MODE_IX1 3'h5
`define ICD_MODE_IX2 3'h6
`define ICD_MODE_REL 3'h7
// register operand select
`define ICD_SRC_NONE 2'h0
`define ICD_SRC_ACC 2'h1
`define ICD_SRC_IDX 2'h2
// opcode rows (high nibble)
`define ICD_ROW_BTB 4'h0
`define ICD_ROW_BMAN 4'h1
`define ICD_ROW_BR 4'h2
`define ICD_ROW_RMW_DIR 4'h3
`define ICD_ROW_RMW_A 4'h4
`define ICD_ROW_RMW_X 4'h5
`define ICD_ROW_RMW_IX1 4'h6
`define ICD_ROW_RMW_IX 4'h7
`define ICD_ROW_CTL0 4'h8
`define ICD_ROW_CTL1 4'h9
`define ICD_ROW_IMM 4'ha
`define ICD_ROW_DIR 4'hb
`define ICD_ROW_EXT 4'hc
`define ICD_ROW_IX2 4'hd
`define ICD_ROW_IX1 4'he
`define ICD_ROW_IX 4'hf
// register/memory low nibble
`define ICD_RM_MINUS 4'h0
`define ICD_RM_ACC_CMP 4'h1
`define ICD_RM_MINUS_BRW 4'h2
`define ICD_RM_IDX_CMP 4'h3
`define ICD_RM_LAND 4'h4
`define ICD_RM_BITTST 4'h5
`define ICD_RM_LOAD_A 4'h6
`define ICD_RM_STORE_A 4'h7
`define ICD_RM_XOR 4'h8
`define ICD_RM_SUM_C 4'h9
`define ICD_RM_LOR 4'ha
`define ICD_RM_SUM 4'hb
`define ICD_RM_JUMP 4'hc
`define ICD_RM_CALL 4'hd
`define ICD_RM_LOAD_X 4'he
`define ICD_RM_STORE_X 4'hf
// read-modify-write low nibble
`define ICD_MW_NEGATE 4'h0
`define ICD_MW_INVERT 4'h3
`define ICD_MW_LSHR 4'h4
`define ICD_MW_ROTR 4'h6
`define ICD_MW_ASHR 4'h7
`define ICD_MW_SHL 4'h8
`define ICD_MW_ROTL 4'h9
`define ICD_MW_MINUS1 4'ha
`define ICD_MW_PLUS1 4'hc
`define ICD_MW_TEST 4'hd
`define ICD_MW_ZERO 4'hf
// whole opcodes
`define ICD_OP_PRODUCT 8'h42
`define ICD_OP_CALL_REL 8'had
`define ICD_OP_RET_INT 8'h80
`define ICD_OP_RET_SUB 8'h81
`define ICD_OP_SOFT_INT 8'h83
`define ICD_OP_HALT_OSC 8'h8e
`define ICD_OP_HALT_CPU 8'h8f
`define ICD_OP_A_TO_X 8'h97
`define ICD_OP_CLR_C 8'h98
`define ICD_OP_SET_C 8'h99
`define ICD_OP_CLR_I 8'h9a
`define ICD_OP_SET_I 8'h9b
`define ICD_OP_SP_INIT 8'h9c
`define ICD_OP_IDLE 8'h9d
`define ICD_OP_X_TO_A 8'h9f
`endif

// File: core/icd_alu.v
// icd_alu.v: arithmetic and logic for register/memory and read-modify-write ops
`timescale 1ns/1ps
`default_nettype none
`include "icd_defines.vh"
module icd_alu (
    // operation select
    input wire rmw_in,
    input wire [3:0] op_in,
    // operands and flags
    input wire [7:0] a_in,
    input wire [7:0] m_in,
    input wire [4:0] ccr_in,
    // result
    output reg [7:0] res_out,
    output reg [4:0] ccr_out
);
    reg [7:0] r;
    reg [4:0] f;
    reg [8:0] s9;
    reg [4:0] h5;
    reg nz;
    wire c_in = ccr_in[`ICD_CCR_C];
    wire cy = (op_in == `ICD_RM_SUM_C) & c_in;

    always @* begin
        r = a_in;
        f = ccr_in;
        s9 = 9'h000;
        h5 = 5'h00;
        nz = 1'b1;
        if (rmw_in) begin
            case (op_in)
                `ICD_MW_NEGATE: begin
                    s9 = 9'h000 - {1'b0, a_in};
                    r = s9[7:0];
                    f[`ICD_CCR_C] = (s9[7:0] != 8'h00);
                end
                `ICD_MW_INVERT: begin
                    r = ~a_in;
                    f[`ICD_CCR_C] = 1'b1;
                end
                `ICD_MW_LSHR: begin
                    r = {1'b0, a_in[7:1]};
                    f[`ICD_CCR_C] = a_in[0];
                end
                `ICD_MW_ROTR: begin
                    r = {c_in, a_in[7:1]};
                    f[`ICD_CCR_C] = a_in[0];
                end
                `ICD_MW_ASHR: begin
                    r = {a_in[7], a_in[7:1]};
                    f[`ICD_CCR_C] = a_in[0];
                end
                `ICD_MW_SHL: begin
                    r = {a_in[6:0], 1'b0};
                    f[`ICD_CCR_C] = a_in[7];
                end
                `ICD_MW_ROTL: begin
                    r = {a_in[6:0], c_in};
                    f[`ICD_CCR_C] = a_in[7];
                end
                `ICD_MW_MINUS1: r = a_in - 8'h01;
                `ICD_MW_PLUS1: r = a_in + 8'h01;
                `ICD_MW_TEST: r = a_in;
                `ICD_MW_ZERO: r = 8'h00;
                default: nz = 1'b0;
            endcase
        end else begin
            case (op_in)
                `ICD_RM_MINUS, `ICD_RM_ACC_CMP, `ICD_RM_IDX_CMP, `ICD_RM_MINUS_BRW: begin
                    // borrow only for the with-borrow form
                    s9 = {1'b0, a_in} - {1'b0, m_in}
                        - {8'h00, c_in & (op_in == `ICD_RM_MINUS_BRW)};
                    r = s9[7:0];
                    f[`ICD_CCR_C] = s9[8];
                end
                `ICD_RM_LAND, `ICD_RM_BITTST: r = a_in & m_in;
                `ICD_RM_LOAD_A, `ICD_RM_LOAD_X: r = m_in;
                `ICD_RM_STORE_A, `ICD_RM_STORE_X: r = a_in;
                `ICD_RM_XOR: r = a_in ^ m_in;
                `ICD_RM_LOR: r = a_in | m_in;
                `ICD_RM_SUM, `ICD_RM_SUM_C: begin
                    h5 = {1'b0, a_in[3:0]} + {1'b0, m_in[3:0]} + {4'h0, cy};
                    s9 = {1'b0, a_in} + {1'b0, m_in} + {8'h00, cy};
                    r = s9[7:0];
                    f[`ICD_CCR_H] = h5[4];
                    f[`ICD_CCR_C] = s9[8];
                end
                default: nz = 1'b0;
            endcase
        end
        // flags an op does not define keep their value
        if (nz) begin
            f[`ICD_CCR_N] = r[7];
            f[`ICD_CCR_Z] = (r == 8'h00);
        end
        res_out = r;
        ccr_out = f;
    end
endmodule
`default_nettype wire

// File: core/icd_decoder.v
// icd_decoder.v: instruction class decoder and executor of one opcode per request
`timescale 1ns/1ps
`default_nettype none
`include "icd_defines.vh"
module icd_decoder (
    // clock and reset
    input wire clk_in,
    input wire rst_n_in,
    // instruction request
    input wire go_in,
    input wire [7:0] opcode_in,
    input wire [7:0] byte2_in,
    input wire [7:0] byte3_in,
    input wire [15:0] pc_next_in,
    // core state
    input wire [7:0] acc_in,
    input wire [7:0] idx_in,
    input wire [7:0] mem_in,
    input wire [4:0] ccr_in,
    // external interrupt pin
    input wire irq_pin_in,
    // decode results
    output reg done_out,
    output reg [2:0] class_out,
    output reg [2:0] mode_out,
    output reg [1:0] src_out,
    output reg [15:0] ea_out,
    output reg mem_rd_out,
    // write back
    output reg mem_wr_out,
    output reg acc_wr_out,
    output reg idx_wr_out,
    output reg [7:0] result_out,
    output reg [7:0] idx_result_out,
    output reg [4:0] ccr_out,
    // sequencing
    output reg pc_load_out,
    output reg [15:0] pc_target_out,
    output reg push_ret_out,
    output reg pop_ret_out,
    output reg pop_ccr_out,
    output reg swi_out,
    output reg sp_reset_out,
    output reg stop_out,
    output reg wait_out,
    output reg illegal_out
);
    wire [3:0] hi = opcode_in[7:4];
    wire [3:0] lo = opcode_in[3:0];

    // pin level: three stages, accepted once stages two and three agree
    reg irq_s1_reg, irq_s2_reg, irq_s3_reg, irq_level_reg;
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_s1_reg <= 1'b1;
            irq_s2_reg <= 1'b1;
            irq_s3_reg <= 1'b1;
            irq_level_reg <= 1'b1;
        end else begin
            irq_s1_reg <= irq_pin_in;
            irq_s2_reg <= irq_s1_reg;
            irq_s3_reg <= irq_s2_reg;
            if (irq_s2_reg == irq_s3_reg)
                irq_level_reg <= irq_s3_reg;
        end
    end

    // sign-extended offset gives -128..+127 from the next address
    function [15:0] rel_target;
        input [15:0] pc;
        input [7:0] off;
        begin
            rel_target = pc + {{8{off[7]}}, off};
        end
    endfunction

    function [15:0] calc_ea;
        input [2:0] mode;
        input [7:0] b2;
        input [7:0] b3;
        input [7:0] x;
        begin
            case (mode)
                `ICD_MODE_DIR: calc_ea = {8'h00, b2};
                `ICD_MODE_EXT: calc_ea = {b2, b3};
                `ICD_MODE_IX: calc_ea = {8'h00, x};
                `ICD_MODE_IX1: calc_ea = {8'h00, b2} + {8'h00, x};
                `ICD_MODE_IX2: calc_ea = {b2, b3} + {8'h00, x};
                default: calc_ea = 16'h0000;
            endcase
        end
    endfunction

    // even opcode tests the base condition, odd one its inverse
    function br_cond;
        input [3:0] n;
        input [4:0] cc;
        input irq;
        reg base;
        begin
            case (n[3:1])
                3'h0: base = 1'b1;
                3'h1: base = ~(cc[`ICD_CCR_C] | cc[`ICD_CCR_Z]);
                3'h2: base = ~cc[`ICD_CCR_C];
                3'h3: base = ~cc[`ICD_CCR_Z];
                3'h4: base = ~cc[`ICD_CCR_H];
                3'h5: base = ~cc[`ICD_CCR_N];
                3'h6: base = ~cc[`ICD_CCR_I];
                default: base = ~irq;
            endcase
            br_cond = base ^ n[0];
        end
    endfunction

    reg [2:0] cls, mode;
    reg [1:0] src;
    reg [15:0] ea, tgt;
    reg mrd, mwr, awr, xwr, pcl, push, pop, popc, swi, sprst, stp, wt, ill;
    reg [7:0] res, xres, alu_a, alu_m, mask;
    reg [4:0] ccr;
    reg alu_rmw, taken, bit_val;
    reg [15:0] prod;
    wire [7:0] alu_res;
    wire [4:0] alu_ccr;

    icd_alu u_alu (
        .rmw_in(alu_rmw),
        .op_in(lo),
        .a_in(alu_a),
        .m_in(alu_m),
        .ccr_in(ccr_in),
        .res_out(alu_res),
        .ccr_out(alu_ccr)
    );

    always @* begin
        cls = `ICD_CLS_ILL;
        mode = `ICD_MODE_INH;
        src = `ICD_SRC_NONE;
        ea = 16'h0000;
        tgt = pc_next_in;
        {mrd, mwr, awr, xwr, pcl, push, pop, popc} = 8'h00;
        {swi, sprst, stp, wt, ill} = 5'h00;
        res = 8'h00;
        xres = 8'h00;
        ccr = ccr_in;
        alu_rmw = 1'b0;
        alu_a = acc_in;
        alu_m = mem_in;
        mask = 8'h01 << lo[3:1];
        taken = 1'b0;
        bit_val = mem_in[lo[3:1]];
        prod = acc_in * idx_in;
        case (hi)
            `ICD_ROW_BTB: begin
                cls = `ICD_CLS_BITMAN;
                mode = `ICD_MODE_DIR;
                ea = calc_ea(`ICD_MODE_DIR, byte2_in, byte3_in, idx_in);
                mrd = 1'b1;
                ccr[`ICD_CCR_C] = bit_val;
                taken = bit_val ^ lo[0];
                pcl = taken;
                tgt = taken ? rel_target(pc_next_in, byte3_in) : pc_next_in;
            end
            `ICD_ROW_BMAN: begin
                cls = `ICD_CLS_BITMAN;
                mode = `ICD_MODE_DIR;
                ea = calc_ea(`ICD_MODE_DIR, byte2_in, byte3_in, idx_in);
                mrd = 1'b1;
                mwr = 1'b1;
                res = lo[0] ? (mem_in & ~mask) : (mem_in | mask);
            end
            `ICD_ROW_BR: begin
                cls = `ICD_CLS_JMPBR;
                mode = `ICD_MODE_REL;
                taken = br_cond(lo, ccr_in, irq_level_reg);
                pcl = taken;
                tgt = taken ? rel_target(pc_next_in, byte2_in) : pc_next_in;
            end
            `ICD_ROW_RMW_DIR, `ICD_ROW_RMW_A, `ICD_ROW_RMW_X,
            `ICD_ROW_RMW_IX1, `ICD_ROW_RMW_IX: begin
                if (opcode_in == `ICD_OP_PRODUCT) begin
                    cls = `ICD_CLS_CTRL;
                    awr = 1'b1;
                    xwr = 1'b1;
                    res = prod[7:0];
                    xres = prod[15:8];
                    ccr[`ICD_CCR_H] = 1'b0;
                    ccr[`ICD_CCR_C] = 1'b0;
                end else if (lo == 4'h1 || lo == 4'h2 || lo == 4'h5
                             || lo == 4'hb || lo == 4'he) begin
                    ill = 1'b1;
                end else begin
                    cls = `ICD_CLS_RMW;
                    alu_rmw = 1'b1;
                    case (hi)
                        `ICD_ROW_RMW_DIR: mode = `ICD_MODE_DIR;
                        `ICD_ROW_RMW_IX1: mode = `ICD_MODE_IX1;
                        `ICD_ROW_RMW_IX: mode = `ICD_MODE_IX;
                        default: mode = `ICD_MODE_INH;
                    endcase
                    ea = calc_ea(mode, byte2_in, byte3_in, idx_in);
                    mrd = (mode != `ICD_MODE_INH);
                    if (hi == `ICD_ROW_RMW_X)
                        alu_a = idx_in;
                    else if (hi == `ICD_ROW_RMW_A)
                        alu_a = acc_in;
                    else
                        alu_a = mem_in;
                    res = alu_res;
                    xres = alu_res;
                    ccr = alu_ccr;
                    // write back to where it was read, never for the
                    if (lo != `ICD_MW_TEST) begin
                        mwr = mrd;
                        awr = (hi == `ICD_ROW_RMW_A);
                        xwr = (hi == `ICD_ROW_RMW_X);
                    end
                end
            end
            `ICD_ROW_CTL0, `ICD_ROW_CTL1: begin
                cls = `ICD_CLS_CTRL;
                case (opcode_in)
                    `ICD_OP_RET_INT: begin
                        pop = 1'b1;
                        popc = 1'b1;
                    end
                    `ICD_OP_RET_SUB: pop = 1'b1;
                    `ICD_OP_SOFT_INT: begin
                        swi = 1'b1;
                        ccr[`ICD_CCR_I] = 1'b1;
                    end
                    `ICD_OP_HALT_OSC: begin
                        stp = 1'b1;
                        ccr[`ICD_CCR_I] = 1'b0;
                    end
                    `ICD_OP_HALT_CPU: begin
                        wt = 1'b1;
                        ccr[`ICD_CCR_I] = 1'b0;
                    end
                    `ICD_OP_A_TO_X: begin
                        xwr = 1'b1;
                        xres = acc_in;
                    end
                    `ICD_OP_X_TO_A: begin
                        awr = 1'b1;
                        res = idx_in;
                    end
                    `ICD_OP_CLR_C: ccr[`ICD_CCR_C] = 1'b0;
                    `ICD_OP_SET_C: ccr[`ICD_CCR_C] = 1'b1;
                    `ICD_OP_CLR_I: ccr[`ICD_CCR_I] = 1'b0;
                    `ICD_OP_SET_I: ccr[`ICD_CCR_I] = 1'b1;
                    `ICD_OP_SP_INIT: sprst = 1'b1;
                    `ICD_OP_IDLE: cls = `ICD_CLS_CTRL;
                    default: begin
                        cls = `ICD_CLS_ILL;
                        ill = 1'b1;
                    end
                endcase
            end
            default: begin
                case (hi)
                    `ICD_ROW_IMM: mode = `ICD_MODE_IMM;
                    `ICD_ROW_DIR: mode = `ICD_MODE_DIR;
                    `ICD_ROW_EXT: mode = `ICD_MODE_EXT;
                    `ICD_ROW_IX2: mode = `ICD_MODE_IX2;
                    `ICD_ROW_IX1: mode = `ICD_MODE_IX1;
                    default: mode = `ICD_MODE_IX;
                endcase
                ea = calc_ea(mode, byte2_in, byte3_in, idx_in);
                if (opcode_in == `ICD_OP_CALL_REL) begin
                    cls = `ICD_CLS_JMPBR;
                    mode = `ICD_MODE_REL;
                    ea = 16'h0000;
                    pcl = 1'b1;
                    push = 1'b1;
                    tgt = rel_target(pc_next_in, byte2_in);
                end else if (mode == `ICD_MODE_IMM && (lo == `ICD_RM_STORE_A
                             || lo == `ICD_RM_JUMP || lo == `ICD_RM_STORE_X)) begin
                    // a store or jump to an immediate has no meaning
                    mode = `ICD_MODE_INH;
                    ea = 16'h0000;
                    ill = 1'b1;
                end else if (lo == `ICD_RM_JUMP || lo == `ICD_RM_CALL) begin
                    cls = `ICD_CLS_JMPBR;
                    pcl = 1'b1;
                    push = (lo == `ICD_RM_CALL);
                    tgt = ea;
                end else begin
                    cls = `ICD_CLS_REGMEM;
                    // index is the register side of compare, load and store
                    if (lo == `ICD_RM_IDX_CMP || lo == `ICD_RM_LOAD_X
                        || lo == `ICD_RM_STORE_X) begin
                        src = `ICD_SRC_IDX;
                        alu_a = idx_in;
                    end else begin
                        src = `ICD_SRC_ACC;
                        alu_a = acc_in;
                    end
                    alu_m = (mode == `ICD_MODE_IMM) ? byte2_in : mem_in;
                    res = alu_res;
                    xres = alu_res;
                    ccr = alu_ccr;
                    if (lo == `ICD_RM_STORE_A || lo == `ICD_RM_STORE_X) begin
                        mwr = 1'b1;
                    end else begin
                        mrd = (mode != `ICD_MODE_IMM);
                        // compares and bit test leave both operands alone
                        xwr = (lo == `ICD_RM_LOAD_X);
                        awr = !(lo == `ICD_RM_ACC_CMP || lo == `ICD_RM_IDX_CMP
                                || lo == `ICD_RM_BITTST || lo == `ICD_RM_LOAD_X);
                    end
                end
            end
        endcase
    end

    // strobes live for one cycle; data outputs hold until the next request
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            done_out <= 1'b0;
            class_out <= `ICD_CLS_ILL;
            mode_out <= `ICD_MODE_INH;
            src_out <= `ICD_SRC_NONE;
            ea_out <= 16'h0000;
            result_out <= 8'h00;
            idx_result_out <= 8'h00;
            ccr_out <= `ICD_CCR_RST;
            pc_target_out <= 16'h0000;
            {mem_rd_out, mem_wr_out, acc_wr_out, idx_wr_out} <= 4'h0;
            {pc_load_out, push_ret_out, pop_ret_out, pop_ccr_out} <= 4'h0;
            {swi_out, sp_reset_out, stop_out, wait_out, illegal_out} <= 5'h00;
        end else begin
            done_out <= go_in;
            {mem_rd_out, mem_wr_out, acc_wr_out, idx_wr_out} <=
                go_in ? {mrd, mwr, awr, xwr} : 4'h0;
            {pc_load_out, push_ret_out, pop_ret_out, pop_ccr_out} <=
                go_in ? {pcl, push, pop, popc} : 4'h0;
            {swi_out, sp_reset_out, stop_out, wait_out, illegal_out} <=
                go_in ? {swi, sprst, stp, wt, ill} : 5'h00;
            if (go_in) begin
                class_out <= cls;
                mode_out <= mode;
                src_out <= src;
                ea_out <= ea;
                result_out <= res;
                idx_result_out <= xres;
                ccr_out <= ill ? ccr_in : ccr;
                pc_target_out <= tgt;
            end
        end
    end
endmodule
`default_nettype wire

// File: tb/icd_chk.sv
// assertions on the decoder ports
`timescale 1ns/1ps
`default_nettype none
`include "icd_defines.vh"
module icd_chk (
    // inputs
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic go_in,
    input wire logic [7:0] opcode_in,
    input wire logic [7:0] byte2_in,
    input wire logic [7:0] byte3_in,
    input wire logic [15:0] pc_next_in,
    input wire logic [7:0] mem_in,
    // outputs
    input wire logic [2:0] class_out,
    input wire logic [2:0] mode_out,
    input wire logic [15:0] ea_out,
    input wire logic mem_wr_out,
    input wire logic acc_wr_out,
    input wire logic idx_wr_out,
    input wire logic [7:0] result_out,
    input wire logic [4:0] ccr_out,
    input wire logic pc_load_out,
    input wire logic [15:0] pc_target_out,
    input wire logic push_ret_out,
    input wire logic stop_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    wire logic bit_sel = mem_in[opcode_in[3:1]];
    wire logic [15:0] rel_tgt = pc_next_in + {{8{byte3_in[7]}}, byte3_in};
    wire logic is_btb = go_in && opcode_in[7:4] == `ICD_ROW_BTB;
    chk_bit_carry: assert property (is_btb |=> ccr_out[`ICD_CCR_C] == $past(bit_sel))
        else $error("tested bit not in carry");
    chk_bit_taken: assert property (is_btb && bit_sel != opcode_in[0] |=>
        pc_load_out && pc_target_out == $past(rel_tgt)) else $error("bit branch target wrong");
    chk_bit_false: assert property (is_btb && bit_sel == opcode_in[0] |=> !pc_load_out)
        else $error("false bit branch loaded pc");
    chk_bit_direct: assert property (go_in && opcode_in[7:5] == 3'h0 |=>
        mode_out == `ICD_MODE_DIR && ea_out == {8'h00, $past(byte2_in)})
        else $error("bit op address not direct");
    chk_test_nowrite: assert property (go_in && opcode_in == 8'h3d |=>
        !mem_wr_out && !acc_wr_out && !idx_wr_out) else $error("test op wrote back");
    chk_jump_noreg: assert property (go_in && opcode_in == 8'hbc |=> pc_load_out &&
        !push_ret_out && !acc_wr_out && pc_target_out == {8'h00, $past(byte2_in)})
        else $error("direct jump wrong");
    chk_rmw_back: assert property (go_in && opcode_in == 8'h33 |=> mem_wr_out &&
        result_out == ~$past(mem_in) && ea_out == {8'h00, $past(byte2_in)})
        else $error("invert not written back");
    chk_ctrl_inh: assert property (go_in && opcode_in == `ICD_OP_A_TO_X |=>
        class_out == `ICD_CLS_CTRL && mode_out == `ICD_MODE_INH && !mem_wr_out)
        else $error("control op not inherent");
    chk_stop_osc: assert property (go_in && opcode_in == `ICD_OP_HALT_OSC |=>
        stop_out && !ccr_out[`ICD_CCR_I]) else $error("stop not flagged");
endmodule
bind icd_decoder icd_chk icd_chk_inst (.clk_in, .rst_n_in, .go_in, .opcode_in, .byte2_in,
    .byte3_in, .pc_next_in, .mem_in, .class_out, .mode_out, .ea_out, .mem_wr_out, .acc_wr_out,
    .idx_wr_out, .result_out, .ccr_out, .pc_load_out, .pc_target_out, .push_ret_out, .stop_out);
`default_nettype wire

// File: tb/tb.sv
// self-checking bench of the instruction class decoder
`timescale 1ns/1ps
`default_nettype none
`include "icd_defines.vh"
module tb;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic go_in = 1'b0;
    logic irq_pin_in = 1'b1;
    logic [7:0] opcode_in = 8'h00, byte2_in = 8'h00, byte3_in = 8'h00;
    logic [7:0] acc_in = 8'h00, idx_in = 8'h22, mem_in = 8'h00;
    logic [15:0] pc_next_in = 16'h1000;
    logic [4:0] ccr_in = 5'h00;
    logic done_out, mem_rd_out, mem_wr_out, acc_wr_out, idx_wr_out, pc_load_out, illegal_out;
    logic push_ret_out, pop_ret_out, pop_ccr_out, swi_out, sp_reset_out, stop_out, wait_out;
    logic [2:0] class_out, mode_out;
    logic [1:0] src_out;
    logic [15:0] ea_out, pc_target_out;
    logic [7:0] result_out, idx_result_out;
    logic [4:0] ccr_out;
    int n_fail = 0;
    int checks = 0;
    icd_decoder icd_decoder_inst (.clk_in, .rst_n_in, .go_in, .opcode_in, .byte2_in, .byte3_in,
        .pc_next_in, .acc_in, .idx_in, .mem_in, .ccr_in, .irq_pin_in, .done_out, .class_out,
        .mode_out, .src_out, .ea_out, .mem_rd_out, .mem_wr_out, .acc_wr_out, .idx_wr_out,
        .result_out, .idx_result_out, .ccr_out, .pc_load_out, .pc_target_out, .push_ret_out,
        .pop_ret_out, .pop_ccr_out, .swi_out, .sp_reset_out, .stop_out, .wait_out, .illegal_out);
    always #25 clk_in = ~clk_in;
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one request, outputs settle one edge later
    task automatic issue(input logic [7:0] op, b2, b3, a, m, input logic [4:0] cc);
        @(posedge clk_in);
        go_in <= 1'b1;
        opcode_in <= op;
        byte2_in <= b2;
        byte3_in <= b3;
        acc_in <= a;
        mem_in <= m;
        ccr_in <= cc;
        @(posedge clk_in);
        go_in <= 1'b0;
        #1;
    endtask
    task automatic t_bit_branch;
        logic [7:0] m;
        logic t;
        for (int k = 0; k < 32; k++) begin
            m = k[4] ? ~(8'h01 << k[3:1]) : (8'h01 << k[3:1]);
            t = m[k[3:1]] ^ k[0];
            issue({4'h0, k[3:0]}, 8'hff, k[0] ? 8'h7f : 8'h80, 8'h00, m, {4'h0, ~m[k[3:1]]});
            check("btb_c", ccr_out[`ICD_CCR_C], m[k[3:1]]);
            check("btb_ea", ea_out, 16'h00ff);
            check("btb_ld", pc_load_out, t);
            if (t) check("btb_tgt", pc_target_out, k[0] ? 16'h107f : 16'h0f80);
        end
    endtask
    task automatic t_bit_write;
        logic [7:0] b;
        for (int k = 0; k < 16; k++) begin
            b = 8'h01 << k[3:1];
            issue({4'h1, k[3:0]}, 8'hc3, 8'h00, 8'h00, 8'h5a, 5'h00);
            check("bw_wr", mem_wr_out, 1'b1);
            check("bw_val", result_out, k[0] ? (8'h5a & ~b) : (8'h5a | b));
            check("bw_ea", ea_out, 16'h00c3);
        end
    endtask
    task automatic t_rmw;
        issue(8'h33, 8'h20, 8'h00, 8'h00, 8'h3c, 5'h00);
        check("inv_c", ccr_out[`ICD_CCR_C], 1'b1);
        issue(8'h3d, 8'h20, 8'h00, 8'h00, 8'h80, 5'h00);
        check("tst_n", ccr_out[`ICD_CCR_N], 1'b1);
        issue(8'h49, 8'h00, 8'h00, 8'h81, 8'h00, 5'h00);
        check("rol", {acc_wr_out, ccr_out[`ICD_CCR_C], result_out}, 10'h302);
        issue(8'h46, 8'h00, 8'h00, 8'h01, 8'h00, 5'h01);
        check("ror", {acc_wr_out, ccr_out[`ICD_CCR_C], result_out}, 10'h380);
        issue(8'h40, 8'h00, 8'h00, 8'h01, 8'h00, 5'h00);
        check("neg", {acc_wr_out, result_out}, 9'h1ff);
    endtask
    task automatic t_regmem;
        logic [7:0] ops[4] = '{8'hbb, 8'hb9, 8'hb0, 8'hb2};
        logic [7:0] res[4] = '{8'h32, 8'h33, 8'hee, 8'hed};
        for (int k = 0; k < 4; k++) begin
            issue(ops[k], 8'h30, 8'h00, 8'h10, 8'h22, 5'h01);
            check("rm_res", {acc_wr_out, src_out, result_out}, {3'h5, res[k]});
        end
        issue(8'hb3, 8'h30, 8'h00, 8'h10, 8'h22, 5'h00);
        check("cpx", {src_out, idx_wr_out, ccr_out[`ICD_CCR_Z]}, 4'h9);
    endtask
    task automatic t_jump_ctrl;
        issue(8'hcd, 8'h12, 8'h34, 8'h00, 8'h00, 5'h00);
        check("jsr", {push_ret_out, pc_load_out, pc_target_out}, 18'h31234);
        issue(8'h97, 8'h00, 8'h00, 8'h5c, 8'h00, 5'h00);
        check("tax", {idx_wr_out, idx_result_out}, 9'h15c);
        issue(8'h9f, 8'h00, 8'h00, 8'h5c, 8'h00, 5'h00);
        check("txa", {acc_wr_out, result_out}, 9'h122);
        issue(8'h9c, 8'h00, 8'h00, 8'h00, 8'h00, 5'h00);
        check("rsp", {sp_reset_out, mode_out}, 4'h8);
        issue(8'h8f, 8'h00, 8'h00, 8'h00, 8'h00, 5'h08);
        check("wait", {wait_out, ccr_out[`ICD_CCR_I]}, 2'h2);
        issue(8'h8e, 8'h00, 8'h00, 8'h00, 8'h00, 5'h08);
        check("stop", {stop_out, wait_out, ccr_out[`ICD_CCR_I]}, 3'h4);
        issue(8'hbc, 8'h45, 8'h00, 8'h00, 8'h00, 5'h00);
        check("jmp", {done_out, class_out, push_ret_out, pc_load_out, pc_target_out}, 22'h290045);
        issue(8'h81, 8'h00, 8'h00, 8'h00, 8'h00, 5'h00);
        check("rts", {pop_ret_out, pop_ccr_out, class_out, mode_out}, 8'ha0);
        issue(8'ha7, 8'h00, 8'h00, 8'h00, 8'h00, 5'h15);
        check("ill", {illegal_out, mem_wr_out, ccr_out}, 7'h55);
    endtask
    task automatic t_irq_mask;
        logic [7:0] ops[8] = '{8'h2e, 8'h2f, 8'h2c, 8'h2d, 8'h20, 8'h21, 8'h2f, 8'h2e};
        // taken per step: pin low, mask set, always and never, then pin high
        logic [7:0] exp_ld = 8'h59;
        for (int k = 0; k < 8; k++) begin
            if (k == 6) irq_pin_in <= 1'b1;
            if (k == 6) repeat (4) @(posedge clk_in);
            issue(ops[k], 8'hfe, 8'h00, 8'h00, 8'h00, 5'h08);
            check("br_ld", pc_load_out, exp_ld[k]);
            check("br_tgt", pc_target_out, exp_ld[k] ? 16'h0ffe : 16'h1000);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #200000;
        n_fail++;
        end_sim;
    end
    initial begin
        repeat (4) @(posedge clk_in);
        rst_n_in <= 1'b1;
        irq_pin_in <= 1'b0;
        t_bit_branch;
        t_bit_write;
        t_rmw;
        t_regmem;
        t_jump_ctrl;
        t_irq_mask;
        end_sim;
    end
endmodule
`default_nettype wire
